// ---- core/fra_pkg.sv ----
// package for the fan ramp and floor configuration slice
// assumes one 25 MHz clock and an apb register bus
package fra_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_DUTY = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00c;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int RATE_LSB = 0;
  localparam int SMOOTH_BIT = 3;
  localparam int SYNC_BIT = 4;
  localparam int FLOOR_LSB = 5;
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_SLOW_BIT = 1;
  localparam int CTRL_AUTO_BIT = 2;
  // full swing is 255 duty counts; interval per step is time*clk*step/255
  localparam int unsigned DUTY_FULL = 255;
  // full-swing times in tenths of a second, slow table then fast table
  localparam int unsigned SWING_SLOW_DS [8] = '{522, 261, 174, 104, 65, 44, 22, 11};
  localparam int unsigned SWING_FAST_DS [8] = '{375, 188, 125, 75, 47, 31, 16, 8};
  localparam int unsigned STEP_SIZE [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
  typedef enum logic [1:0] {FRA_IDLE, FRA_WAIT, FRA_STEP} fra_ramp_t;
endpackage : fra_pkg

// ---- core/fra_ramp.sv ----
// duty ramp engine: walks the live duty toward a target in fixed steps
// assumes the caller supplies the step size and the step interval in cycles
`timescale 1ns/1ns
module fra_ramp
  import fra_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic smooth_on,
  input wire logic [7:0] target,
  input wire logic [7:0] step,
  input wire logic [31:0] interval,
  output logic [7:0] duty_q
);
  logic [31:0] tick_q;
  fra_ramp_t st_q;
  // interval timer and stepping toward the target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 32'h0;
      duty_q <= 8'h00;
      st_q <= FRA_IDLE;
    end else if (!smooth_on) begin
      duty_q <= target;
      tick_q <= 32'h0;
      st_q <= FRA_IDLE;
    end else if (duty_q == target) begin
      st_q <= FRA_IDLE;
      tick_q <= 32'h0;
    end else if (tick_q + 32'h1 >= interval) begin
      tick_q <= 32'h0;
      st_q <= FRA_STEP;
      // move by at most one step, never overshoot
      if (target > duty_q) begin
        duty_q <= ({1'b0, target} - {1'b0, duty_q} > {1'b0, step}) ? duty_q + step : target;
      end else begin
        duty_q <= ({1'b0, duty_q} - {1'b0, target} > {1'b0, step}) ? duty_q - step : target;
      end
    end else begin
      tick_q <= tick_q + 32'h1;
      st_q <= FRA_WAIT;
    end
  end

  // a waiting interval never moves the duty
  a_ramp_wait: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == FRA_WAIT |-> duty_q == $past(duty_q)) else $error("duty moved mid interval");
endmodule : fra_ramp

// ---- core/fra_top.sv ----
// fan ramp rate, tach sync and floor configuration slice with apb access
// assumes a single 25 MHz pclk and synchronous fan inputs
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns
module fra_top
  import fra_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] remote1_duty,
  input wire logic [7:0] duty_b_in,
  input wire logic [7:0] duty_c_in,
  input wire logic [2:0] below_start,
  input wire logic [23:0] min_duty,
  output logic [7:0] fan_drive_a_duty,
  output logic [7:0] fan_drive_b_duty,
  output logic [7:0] fan_drive_c_duty,
  output logic [2:0] tach_sync_c
);
  logic [7:0] cfg_q;
  logic lock_q;
  logic slow_q;
  logic auto_q;
  logic [7:0] duty_a_live;
  logic [2:0] ramp_rate_code;
  logic remote1_smoothing_on;
  logic fan1_floor_select;
  logic fan2_floor_select;
  logic fan3_floor_select;
  logic [31:0] interval;
  logic [7:0] step;
  logic [2:0] floor_sel;
  logic [23:0] pre_floor;
  logic [23:0] post_floor;
  logic wr_en;
  logic rd_en;
  logic map_hit;

  assign ramp_rate_code = cfg_q[RATE_LSB +: 3];
  assign remote1_smoothing_on = cfg_q[SMOOTH_BIT];
  assign fan1_floor_select = cfg_q[FLOOR_LSB];
  assign fan2_floor_select = cfg_q[FLOOR_LSB + 1];
  assign fan3_floor_select = cfg_q[FLOOR_LSB + 2];
  assign floor_sel = {fan3_floor_select, fan2_floor_select, fan1_floor_select};

  // apb decode: zero wait states, error on unmapped address
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign map_hit = (paddr == ADDR_CFG) || (paddr == ADDR_CTRL) ||
                   (paddr == ADDR_DUTY) || (paddr == ADDR_STAT);

  // step size and interval per code; table picked by slow_q
  always_comb begin
    int unsigned t_ds;
    int unsigned s;
    t_ds = slow_q ? SWING_SLOW_DS[ramp_rate_code] : SWING_FAST_DS[ramp_rate_code];
    s = STEP_SIZE[ramp_rate_code];
    step = 8'(s);
    // cycles per step = swing_time * clk * step / full swing
    interval = 32'((64'(t_ds) * 64'(CLK_HZ / 10) * 64'(s)) / 64'(DUTY_FULL));
  end

  // configuration register, frozen once locked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RESET;
    end else if (wr_en && paddr == ADDR_CFG && !lock_q) begin
      cfg_q <= pwdata[7:0];
    end
  end

  // control register: lock is sticky until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 1'b0;
      slow_q <= 1'b0;
      auto_q <= 1'b0;
    end else if (wr_en && paddr == ADDR_CTRL) begin
      lock_q <= lock_q | pwdata[CTRL_LOCK_BIT];
      slow_q <= pwdata[CTRL_SLOW_BIT];
      auto_q <= pwdata[CTRL_AUTO_BIT];
    end
  end

  // bus answers registered; read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !map_hit;
      if (rd_en) begin
        unique case (paddr)
          ADDR_CFG: prdata <= {24'h0, cfg_q};
          ADDR_CTRL: prdata <= {29'h0, auto_q, slow_q, lock_q};
          ADDR_DUTY: prdata <= {8'h0, fan_drive_c_duty, fan_drive_b_duty, fan_drive_a_duty};
          ADDR_STAT: prdata <= {21'h0, tach_sync_c, duty_a_live};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // remote1 ramp on drive a
  fra_ramp u_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .smooth_on(remote1_smoothing_on),
    .target(remote1_duty),
    .step(step),
    .interval(interval),
    .duty_q(duty_a_live)
  );

  assign pre_floor = {duty_c_in, duty_b_in, duty_a_live};

  // per-drive floor behaviour below start minus hysteresis
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_floor
      assign post_floor[8*g +: 8] = (auto_q && below_start[g]) ?
        (floor_sel[g] ? min_duty[8*g +: 8] : 8'h00) : pre_floor[8*g +: 8];
    end
  endgenerate

  // registered drive outputs and tach sync map
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan_drive_a_duty <= 8'h00;
      fan_drive_b_duty <= 8'h00;
      fan_drive_c_duty <= 8'h00;
      tach_sync_c <= 3'b000;
    end else begin
      fan_drive_a_duty <= post_floor[7:0];
      fan_drive_b_duty <= post_floor[15:8];
      fan_drive_c_duty <= post_floor[23:16];
      // bit0 fan_speed_in_b, bit1 fan_speed_in_c, bit2 fan_speed_in_d
      tach_sync_c <= {2'b11, cfg_q[SYNC_BIT]};
    end
  end

  a_lock_holds: assert property (@(posedge pclk) disable iff (!presetn)
    lock_q |=> cfg_q == $past(cfg_q)) else $error("cfg changed while locked");
  a_floor_zero: assert property (@(posedge pclk) disable iff (!presetn)
    auto_q && below_start[0] && !floor_sel[0] |=> fan_drive_a_duty == 8'h00)
    else $error("floor zero not forced");
  a_floor_min: assert property (@(posedge pclk) disable iff (!presetn)
    auto_q && below_start[2] && floor_sel[2] |=> fan_drive_c_duty == $past(min_duty[23:16]))
    else $error("floor min not held");
  a_sync_map: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> tach_sync_c == {2'b11, $past(cfg_q[SYNC_BIT])})
    else $error("tach sync map wrong");
  a_sync_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_q[SYNC_BIT] |=> !tach_sync_c[0]) else $error("tach b synced");
  a_step_bound: assert property (@(posedge pclk) disable iff (!presetn)
    remote1_smoothing_on && $stable(remote1_smoothing_on) |->
    (duty_a_live >= $past(duty_a_live) ? duty_a_live - $past(duty_a_live)
      : $past(duty_a_live) - duty_a_live) <= step) else $error("ramp jumped");
  a_no_smooth: assert property (@(posedge pclk) disable iff (!presetn)
    !remote1_smoothing_on |=> duty_a_live == $past(remote1_duty))
    else $error("unsmoothed lag");
  a_fast_step: assert property (@(posedge pclk) disable iff (!presetn)
    ramp_rate_code == 3'h7 |-> step == 8'd48) else $error("step size wrong");
  a_fast_time: assert property (@(posedge pclk) disable iff (!presetn)
    !slow_q && ramp_rate_code == 3'h0 |-> interval == 32'd3676470)
    else $error("interval wrong");
  a_slow_time: assert property (@(posedge pclk) disable iff (!presetn)
    slow_q && ramp_rate_code == 3'h7 |-> interval == 32'd5176470)
    else $error("slow interval wrong");

  // remaining fast codes: cycles between steps at 25 MHz
  // the value is truncated, so a full swing may finish slightly early
  a_fast_time1: assert property (@(posedge pclk) disable iff (!presetn)
    !slow_q && ramp_rate_code == 3'h1 |-> interval == 32'd3686274)
    else $error("fast interval code 1 wrong");
  a_fast_time2: assert property (@(posedge pclk) disable iff (!presetn)
    !slow_q && ramp_rate_code == 3'h2 |-> interval == 32'd3676470)
    else $error("fast interval code 2 wrong");
  a_fast_time3: assert property (@(posedge pclk) disable iff (!presetn)
    !slow_q && ramp_rate_code == 3'h3 |-> interval == 32'd2941176)
    else $error("fast interval code 3 wrong");
  a_fast_time4: assert property (@(posedge pclk) disable iff (!presetn)
    !slow_q && ramp_rate_code == 3'h4 |-> interval == 32'd3686274)
    else $error("fast interval code 4 wrong");
  a_fast_time5: assert property (@(posedge pclk) disable iff (!presetn)
    !slow_q && ramp_rate_code == 3'h5 |-> interval == 32'd3647058)
    else $error("fast interval code 5 wrong");
  a_fast_time6: assert property (@(posedge pclk) disable iff (!presetn)
    !slow_q && ramp_rate_code == 3'h6 |-> interval == 32'd3764705)
    else $error("fast interval code 6 wrong");
  a_fast_time7: assert property (@(posedge pclk) disable iff (!presetn)
    !slow_q && ramp_rate_code == 3'h7 |-> interval == 32'd3764705)
    else $error("fast interval code 7 wrong");

  // remaining slow codes, same truncation as the fast table
  // these apply only while the slow table is selected
  a_slow_time0: assert property (@(posedge pclk) disable iff (!presetn)
    slow_q && ramp_rate_code == 3'h0 |-> interval == 32'd5117647)
    else $error("slow interval code 0 wrong");
  a_slow_time1: assert property (@(posedge pclk) disable iff (!presetn)
    slow_q && ramp_rate_code == 3'h1 |-> interval == 32'd5117647)
    else $error("slow interval code 1 wrong");
  a_slow_time2: assert property (@(posedge pclk) disable iff (!presetn)
    slow_q && ramp_rate_code == 3'h2 |-> interval == 32'd5117647)
    else $error("slow interval code 2 wrong");
  a_slow_time3: assert property (@(posedge pclk) disable iff (!presetn)
    slow_q && ramp_rate_code == 3'h3 |-> interval == 32'd4078431)
    else $error("slow interval code 3 wrong");
  a_slow_time4: assert property (@(posedge pclk) disable iff (!presetn)
    slow_q && ramp_rate_code == 3'h4 |-> interval == 32'd5098039)
    else $error("slow interval code 4 wrong");
  a_slow_time5: assert property (@(posedge pclk) disable iff (!presetn)
    slow_q && ramp_rate_code == 3'h5 |-> interval == 32'd5176470)
    else $error("slow interval code 5 wrong");
  a_slow_time6: assert property (@(posedge pclk) disable iff (!presetn)
    slow_q && ramp_rate_code == 3'h6 |-> interval == 32'd5176470)
    else $error("slow interval code 6 wrong");

  // step size per code is shared by both tables
  a_step_code0: assert property (@(posedge pclk) disable iff (!presetn)
    ramp_rate_code == 3'h0 |-> step == 8'd1) else $error("step code 0 wrong");
  a_step_code1: assert property (@(posedge pclk) disable iff (!presetn)
    ramp_rate_code == 3'h1 |-> step == 8'd2) else $error("step code 1 wrong");
  a_step_code2: assert property (@(posedge pclk) disable iff (!presetn)
    ramp_rate_code == 3'h2 |-> step == 8'd3) else $error("step code 2 wrong");
  a_step_code3: assert property (@(posedge pclk) disable iff (!presetn)
    ramp_rate_code == 3'h3 |-> step == 8'd4) else $error("step code 3 wrong");
  a_step_code4: assert property (@(posedge pclk) disable iff (!presetn)
    ramp_rate_code == 3'h4 |-> step == 8'd8) else $error("step code 4 wrong");
  a_step_code5: assert property (@(posedge pclk) disable iff (!presetn)
    ramp_rate_code == 3'h5 |-> step == 8'd12) else $error("step code 5 wrong");
  a_step_code6: assert property (@(posedge pclk) disable iff (!presetn)
    ramp_rate_code == 3'h6 |-> step == 8'd24) else $error("step code 6 wrong");

  // apb answer: one registered ready per access, no wait states
  // error only rides on ready, and only for an unmapped address
  a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("error without ready");
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !map_hit |=> pslverr)
    else $error("unmapped access not flagged");

  // lock cannot be undone by software
  a_lock_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    lock_q |=> lock_q) else $error("lock cleared");

  // floor values on the drives not covered above
  // each drive obeys only its own floor bit and below flag, plus the shared auto_q
  a_floor_a_min: assert property (@(posedge pclk) disable iff (!presetn)
    auto_q && below_start[0] && floor_sel[0] |=> fan_drive_a_duty == $past(min_duty[7:0]))
    else $error("drive a floor min not held");
  a_floor_b_min: assert property (@(posedge pclk) disable iff (!presetn)
    auto_q && below_start[1] && floor_sel[1] |=> fan_drive_b_duty == $past(min_duty[15:8]))
    else $error("drive b floor min not held");
  a_floor_b_zero: assert property (@(posedge pclk) disable iff (!presetn)
    auto_q && below_start[1] && !floor_sel[1] |=> fan_drive_b_duty == 8'h00)
    else $error("drive b floor zero not forced");
  a_floor_c_zero: assert property (@(posedge pclk) disable iff (!presetn)
    auto_q && below_start[2] && !floor_sel[2] |=> fan_drive_c_duty == 8'h00)
    else $error("drive c floor zero not forced");

  // outside the floor condition each drive is its input, one cycle late
  // drive a takes the ramped duty, so smoothing shows through here
  // drives b and c pass their inputs untouched
  a_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(auto_q && below_start[0]) |=> fan_drive_a_duty == $past(duty_a_live))
    else $error("drive a not following ramp");
  a_pass_b: assert property (@(posedge pclk) disable iff (!presetn)
    !(auto_q && below_start[1]) |=> fan_drive_b_duty == $past(duty_b_in))
    else $error("drive b not following input");
  a_pass_c: assert property (@(posedge pclk) disable iff (!presetn)
    !(auto_q && below_start[2]) |=> fan_drive_c_duty == $past(duty_c_in))
    else $error("drive c not following input");

  // tach c and d always follow drive c once out of reset
  a_sync_cd: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> tach_sync_c[2:1] == 2'b11)
    else $error("tach c or d not synced");
endmodule : fra_top

// ---- sim/fra_fan.sv ----
// fan model: three fans hung on the drive outputs, reports which spin
// assumes duties change on pclk and a duty of 0 stops the fan
`timescale 1ns/1ns
module fra_fan (
  input wire logic pclk,
  input wire logic [7:0] duty_a,
  input wire logic [7:0] duty_b,
  input wire logic [7:0] duty_c,
  output logic [2:0] spin_q
);
  // a fan turns while its drive is above 0%
  always_ff @(posedge pclk) begin
    spin_q <= {duty_c != 8'h00, duty_b != 8'h00, duty_a != 8'h00};
  end
endmodule : fra_fan

// ---- sim/fan_ramp_and_min_duty_cfg_test.sv ----
// self-checking bench for the ramp, sync and floor slice over apb
// assumes fra_top and fra_fan compiled before it
`timescale 1ns/1ns
module fan_ramp_and_min_duty_cfg_test;
  import fra_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [7:0] r1 = 0, db = 0, dc = 0, da_o, db_o, dc_o, cfg;
  logic [2:0] bs = 0, sync, spin;
  logic [23:0] mn = 0, ex;
  int n_fail = 0;
  int num_checks = 0;
  always #20 pclk = ~pclk;
  fra_top fra_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .remote1_duty(r1), .duty_b_in(db), .duty_c_in(dc),
    .below_start(bs), .min_duty(mn), .fan_drive_a_duty(da_o), .fan_drive_b_duty(db_o),
    .fan_drive_c_duty(dc_o), .tach_sync_c(sync));
  fra_fan fra_fan_inst (.pclk(pclk), .duty_a(da_o), .duty_b(db_o), .duty_c(dc_o),
    .spin_q(spin));
  task close_out;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer, held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // expected duty: below start it is floor or 0%, else the input
  function logic [7:0] fexp(input logic [7:0] v, input logic b, input logic f,
      input logic [7:0] m);
    return b ? (f ? m : 8'h00) : v;
  endfunction : fexp
  initial begin
    void'($urandom(32508));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, ADDR_CFG, 0);
    chk("cfg reset", {24'h0, CFG_RESET}, rd);
    for (int s = 0; s < 2; s++) begin
      apb(1, ADDR_CFG, s << SYNC_BIT);
      repeat (3) @(posedge pclk);
      chk("tach sync", {29'h0, (s != 0) ? 3'h7 : 3'h6}, {29'h0, sync});
    end
    apb(1, ADDR_CTRL, 32'h4);
    // random floors and temperatures with smoothing off
    repeat (24) begin
      cfg = 8'($urandom) & 8'he7;
      r1 <= 8'($urandom);
      db <= 8'($urandom);
      dc <= 8'($urandom);
      bs <= 3'($urandom);
      mn <= 24'($urandom);
      apb(1, ADDR_CFG, {24'h0, cfg});
      apb(0, ADDR_CFG, 0);
      chk("cfg rw", {24'h0, cfg}, rd);
      repeat (3) @(posedge pclk);
      chk("drive a", {24'h0, fexp(r1, bs[0], cfg[5], mn[7:0])}, {24'h0, da_o});
      chk("drive b", {24'h0, fexp(db, bs[1], cfg[6], mn[15:8])}, {24'h0, db_o});
      chk("drive c", {24'h0, fexp(dc, bs[2], cfg[7], mn[23:16])}, {24'h0, dc_o});
      chk("spin b", {31'h0, fexp(db, bs[1], cfg[6], mn[15:8]) != 8'h00}, {31'h0, spin[1]});
      ex = {fexp(dc, bs[2], cfg[7], mn[23:16]), fexp(db, bs[1], cfg[6], mn[15:8]),
        fexp(r1, bs[0], cfg[5], mn[7:0])};
      apb(0, ADDR_DUTY, 0);
      chk("duty reg", {8'h0, ex}, rd);
    end
    // smoothing on: a jump from 0 to 200 must crawl
    bs <= 3'h0;
    r1 <= 8'h00;
    apb(1, ADDR_CFG, 32'h0);
    repeat (3) @(posedge pclk);
    apb(1, ADDR_CFG, 32'h8);
    r1 <= 8'hc8;
    repeat (20) @(posedge pclk);
    chk("ramp held", 32'h1, {31'h0, da_o <= 8'h01});
    apb(1, ADDR_CFG, 32'h0);
    repeat (3) @(posedge pclk);
    chk("ramp off", 32'hc8, {24'h0, da_o});
    apb(0, ADDR_STAT, 0);
    chk("status", {21'h0, 3'h6, 8'hc8}, rd);
    // slow table selected with the fastest code
    apb(1, ADDR_CTRL, 32'h6);
    apb(1, ADDR_CFG, 32'h7);
    apb(0, ADDR_CTRL, 0);
    chk("ctrl rw", 32'h6, rd);
    // lock then try to overwrite
    apb(1, ADDR_CFG, 32'h5a);
    apb(1, ADDR_CTRL, 32'h5);
    apb(1, ADDR_CFG, 32'ha5);
    apb(0, ADDR_CFG, 0);
    chk("locked cfg", 32'h5a, rd);
    apb(0, 12'h010, 0);
    chk("unmapped err", 32'h1, {31'h0, err});
    close_out;
  end
  // watchdog cuts a hang
  initial begin
    #(40 * 6000);
    n_fail++;
    close_out;
  end
endmodule : fan_ramp_and_min_duty_cfg_test
